// File: src/ucd_config_source.sv
// Configuration, interface and endpoint descriptor source with APB access
`timescale 1ns/1ps

// Functional notes
// - Configuration fields other than the type come from the stored copy once loaded, identical for both speeds.
// - The type byte of the configuration descriptor is always the fixed code 02h.
// - Length 9, total length 39, one interface and configuration value one.
// - Attributes default to A0h, adjusted by the power and wakeup straps.
// - Max power defaults to 01h when self powered and FAh when bus powered.
// - Configuration string index is stored, defaulting to zero.
// - Interface 0 header is stored, default length 9, type 04h, number 0, alternate 0, three endpoints.
// - Interface string, class, subclass and protocol are stored, default 0, FFh, 0, FFh.
// - Endpoint 1 is fixed: length 7, type 05h, address 81h, bulk, interval 0.
// - Endpoint 1 max packet is 64 at full speed and 512 at high speed.
// - Endpoint 2 is fixed: length 7, type 05h, address 02h, bulk, interval 0.
// - Endpoint 2 max packet is 64 at full speed and 512 at high speed.
// - Endpoint 3: length 7, type 05h, address 83h, interrupt, max packet 16.
// - Only the endpoint 3 interval is stored, one value per speed chosen by speed.
// - Without stored values the interval is 04h at high speed and 01h at full speed.
module ucd_config_source (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Straps and speed
    input  wire logic        powerSourceStrap,
    input  wire logic        remoteWakeupStrap,
    input  wire logic        highSpeed,
    // Descriptor request
    input  wire logic        reqValid,
    input  wire logic [15:0] reqLength,
    output logic             reqReady,
    // Descriptor byte stream
    output logic             txValid,
    output logic [7:0]       txData,
    output logic             txLast,
    input  wire logic        txReady
);

    ////////////////////////////////////////////////////////////////////
    logic        loaded_reg;
    logic [31:0] cfg0_reg;
    logic [31:0] cfg1_reg;
    logic [31:0] cfg2_reg;
    logic [31:0] if0_reg;
    logic [31:0] if1_reg;
    logic [31:0] if2_reg;
    logic [31:0] epInt_reg;
    logic [2:0]  pwrSync_reg;
    logic [2:0]  wakeSync_reg;
    logic        pwrFilt_reg;
    logic        wakeFilt_reg;
    logic        selfPowered_reg;
    logic        wakeEnable_reg;
    logic        strapDone_reg;
    logic [1:0]  strapCnt_reg;
    ucd_pkg::ucd_state_e state_reg;
    logic [5:0]  index_reg;
    logic [5:0]  lastIdx_reg;
    logic [5:0]  index_next;
    logic        apbSetup;
    logic        apbWrite;
    logic        mapped;
    logic        fire;
    logic [7:0]  attrDef;
    logic [7:0]  powerDef;
    logic [7:0]  byteAt;

    ////////////////////////////////////////////////////////////////////
    // APB decode, zero wait states
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite && mapped;
    assign pready   = 1'b1;

    always_comb begin
        case (paddr)
            ucd_pkg::CTRL_OFF, ucd_pkg::STAT_OFF, ucd_pkg::CFG0_OFF,
            ucd_pkg::CFG1_OFF, ucd_pkg::CFG2_OFF, ucd_pkg::IF0_OFF,
            ucd_pkg::IF1_OFF, ucd_pkg::IF2_OFF,
            ucd_pkg::EPINT_OFF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            loaded_reg <= 1'b0;
            cfg0_reg   <= ucd_pkg::CFG0_RST;
            cfg1_reg   <= ucd_pkg::CFG1_RST;
            cfg2_reg   <= ucd_pkg::CFG2_RST;
            if0_reg    <= ucd_pkg::IF0_RST;
            if1_reg    <= ucd_pkg::IF1_RST;
            if2_reg    <= ucd_pkg::IF2_RST;
            epInt_reg  <= ucd_pkg::EPINT_RST;
        end else if (apbWrite) begin
            case (paddr)
                ucd_pkg::CTRL_OFF:  loaded_reg <= pwdata[ucd_pkg::CTRL_LOADED_BIT];
                ucd_pkg::CFG0_OFF:  cfg0_reg   <= pwdata;
                ucd_pkg::CFG1_OFF:  cfg1_reg   <= pwdata;
                ucd_pkg::CFG2_OFF:  cfg2_reg   <= {24'h0, pwdata[7:0]};
                ucd_pkg::IF0_OFF:   if0_reg    <= pwdata;
                ucd_pkg::IF1_OFF:   if1_reg    <= pwdata;
                ucd_pkg::IF2_OFF:   if2_reg    <= {24'h0, pwdata[7:0]};
                ucd_pkg::EPINT_OFF: epInt_reg  <= {16'h0, pwdata[15:0]};
                default: loaded_reg <= loaded_reg;
            endcase
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (apbSetup) begin
            case (paddr)
                ucd_pkg::CTRL_OFF:  prdata <= {31'h0, loaded_reg};
                ucd_pkg::STAT_OFF:  prdata <= {27'h0, strapDone_reg,
                                               state_reg == ucd_pkg::ST_SEND,
                                               wakeEnable_reg, selfPowered_reg,
                                               highSpeed};
                ucd_pkg::CFG0_OFF:  prdata <= cfg0_reg;
                ucd_pkg::CFG1_OFF:  prdata <= cfg1_reg;
                ucd_pkg::CFG2_OFF:  prdata <= cfg2_reg;
                ucd_pkg::IF0_OFF:   prdata <= if0_reg;
                ucd_pkg::IF1_OFF:   prdata <= if1_reg;
                ucd_pkg::IF2_OFF:   prdata <= if2_reg;
                ucd_pkg::EPINT_OFF: prdata <= epInt_reg;
                default:            prdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strap synchronisers; a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pwrSync_reg  <= 3'h0;
            wakeSync_reg <= 3'h0;
            pwrFilt_reg  <= 1'b0;
            wakeFilt_reg <= 1'b0;
        end else begin
            pwrSync_reg  <= {pwrSync_reg[1:0], powerSourceStrap};
            wakeSync_reg <= {wakeSync_reg[1:0], remoteWakeupStrap};
            if (pwrSync_reg[1] == pwrSync_reg[2]) begin
                pwrFilt_reg <= pwrSync_reg[2];
            end
            if (wakeSync_reg[1] == wakeSync_reg[2]) begin
                wakeFilt_reg <= wakeSync_reg[2];
            end
        end
    end

    // Straps caught once after reset release, then held
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strapCnt_reg    <= 2'h0;
            strapDone_reg   <= 1'b0;
            selfPowered_reg <= 1'b0;
            wakeEnable_reg  <= 1'b1;
        end else if (!strapDone_reg) begin
            if (strapCnt_reg == ucd_pkg::STRAP_WAIT) begin
                strapDone_reg   <= 1'b1;
                // Filter's next value; the filter itself settles one cycle later
                selfPowered_reg <= (pwrSync_reg[1] == pwrSync_reg[2]) ? pwrSync_reg[2] : pwrFilt_reg;
                wakeEnable_reg  <= (wakeSync_reg[1] == wakeSync_reg[2]) ? wakeSync_reg[2] : wakeFilt_reg;
            end else begin
                strapCnt_reg <= strapCnt_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Strap-dependent defaults
    always_comb begin
        attrDef = ucd_pkg::ATTR_DEF;
        attrDef[ucd_pkg::ATTR_SELF_BIT] = selfPowered_reg;
        attrDef[ucd_pkg::ATTR_WAKE_BIT] = wakeEnable_reg;
        powerDef = selfPowered_reg ? ucd_pkg::PWR_SELF : ucd_pkg::PWR_BUS;
    end

    ////////////////////////////////////////////////////////////////////
    // Byte of the combined response at a given position
    function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] b);
        pick = w[8*b +: 8];
    endfunction

    always_comb begin
        logic [15:0] mps;
        logic [5:0]  rel;
        logic [7:0]  ivl;
        mps = highSpeed ? ucd_pkg::MPS_HS : ucd_pkg::MPS_FS;
        ivl = highSpeed ? epInt_reg[15:8] : epInt_reg[7:0];
        if (!loaded_reg) begin
            ivl = highSpeed ? ucd_pkg::IVL_HS_DEF : ucd_pkg::IVL_FS_DEF;
        end
        rel = 6'h0;
        byteAt = 8'h0;
        if (index_reg < ucd_pkg::IF_BASE) begin
            // Stored copy, once loaded, used at either speed for all but the type byte
            case (index_reg)
                6'd0: byteAt = loaded_reg ? pick(cfg0_reg, 2'd0) : ucd_pkg::CFG_LEN;
                6'd1: byteAt = ucd_pkg::CFG_TYPE;
                6'd2: byteAt = loaded_reg ? pick(cfg0_reg, 2'd2) : ucd_pkg::TOTAL_LEN[7:0];
                6'd3: byteAt = loaded_reg ? pick(cfg0_reg, 2'd3) : ucd_pkg::TOTAL_LEN[15:8];
                6'd4: byteAt = loaded_reg ? pick(cfg1_reg, 2'd0) : ucd_pkg::NUM_IF;
                6'd5: byteAt = loaded_reg ? pick(cfg1_reg, 2'd1) : ucd_pkg::CFG_VALUE;
                6'd6: byteAt = loaded_reg ? pick(cfg1_reg, 2'd2) : ucd_pkg::STR_NONE;
                6'd7: byteAt = loaded_reg ? pick(cfg1_reg, 2'd3) : attrDef;
                default: byteAt = loaded_reg ? pick(cfg2_reg, 2'd0) : powerDef;
            endcase
        end else if (index_reg < ucd_pkg::EP1_BASE) begin
            rel = index_reg - ucd_pkg::IF_BASE;
            case (rel)
                6'd0: byteAt = loaded_reg ? pick(if0_reg, 2'd0) : ucd_pkg::IF_LEN;
                6'd1: byteAt = loaded_reg ? pick(if0_reg, 2'd1) : ucd_pkg::IF_TYPE;
                6'd2: byteAt = loaded_reg ? pick(if0_reg, 2'd2) : ucd_pkg::IF_NUM;
                6'd3: byteAt = loaded_reg ? pick(if0_reg, 2'd3) : ucd_pkg::IF_ALT;
                6'd4: byteAt = loaded_reg ? pick(if1_reg, 2'd0) : ucd_pkg::IF_NUM_EP;
                6'd5: byteAt = loaded_reg ? pick(if1_reg, 2'd1) : ucd_pkg::IF_CLASS;
                6'd6: byteAt = loaded_reg ? pick(if1_reg, 2'd2) : ucd_pkg::IF_SUB;
                6'd7: byteAt = loaded_reg ? pick(if1_reg, 2'd3) : ucd_pkg::IF_PROTO;
                default: byteAt = loaded_reg ? pick(if2_reg, 2'd0) : ucd_pkg::STR_NONE;
            endcase
        end else begin
            // Endpoints share a layout; only address, type, size and interval differ
            if (index_reg < ucd_pkg::EP2_BASE) begin
                rel = index_reg - ucd_pkg::EP1_BASE;
            end else if (index_reg < ucd_pkg::EP3_BASE) begin
                rel = index_reg - ucd_pkg::EP2_BASE;
            end else begin
                rel = index_reg - ucd_pkg::EP3_BASE;
            end
            case (rel)
                6'd0: byteAt = ucd_pkg::EP_LEN;
                6'd1: byteAt = ucd_pkg::EP_TYPE;
                6'd2: byteAt = index_reg < ucd_pkg::EP2_BASE ? ucd_pkg::EP1_ADDR :
                               index_reg < ucd_pkg::EP3_BASE ? ucd_pkg::EP2_ADDR :
                               ucd_pkg::EP3_ADDR;
                6'd3: byteAt = index_reg < ucd_pkg::EP3_BASE ? ucd_pkg::EP_BULK :
                               ucd_pkg::EP_INTR;
                6'd4: byteAt = index_reg < ucd_pkg::EP3_BASE ? mps[7:0] :
                               ucd_pkg::MPS_INT[7:0];
                6'd5: byteAt = index_reg < ucd_pkg::EP3_BASE ? mps[15:8] :
                               ucd_pkg::MPS_INT[15:8];
                default: byteAt = index_reg < ucd_pkg::EP3_BASE ? ucd_pkg::BULK_IVL :
                                  ivl;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Response sequencer
    assign reqReady = (state_reg == ucd_pkg::ST_IDLE);
    assign fire     = txValid && txReady;
    assign index_next = index_reg + 6'h1;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= ucd_pkg::ST_IDLE;
            index_reg   <= 6'h0;
            lastIdx_reg <= 6'h0;
        end else begin
            case (state_reg)
                ucd_pkg::ST_IDLE: begin
                    if (reqValid && reqLength != 16'h0) begin
                        state_reg <= ucd_pkg::ST_SEND;
                        index_reg <= 6'h0;
                        if (reqLength < ucd_pkg::TOTAL_LEN) begin
                            lastIdx_reg <= 6'(reqLength - 16'h1);
                        end else begin
                            lastIdx_reg <= 6'(ucd_pkg::TOTAL_LEN - 16'h1);
                        end
                    end
                end
                ucd_pkg::ST_SEND: begin
                    if (fire && txLast) begin
                        state_reg <= ucd_pkg::ST_IDLE;
                    end else if (!txValid || fire) begin
                        // Index runs one ahead of the byte on show
                        index_reg <= index_next;
                    end
                end
                default: state_reg <= ucd_pkg::ST_IDLE;
            endcase
        end
    end

    // Output byte register, loaded whenever the slot is empty or taken
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            txValid <= 1'b0;
            txData  <= 8'h0;
            txLast  <= 1'b0;
        end else if (state_reg == ucd_pkg::ST_SEND && (!txValid || fire)) begin
            if (fire && txLast) begin
                txValid <= 1'b0;
                txLast  <= 1'b0;
            end else begin
                txValid <= 1'b1;
                txData  <= byteAt;
                txLast  <= index_reg == lastIdx_reg;
            end
        end
    end

endmodule

// File: shared/ucd_pkg.sv
// Constants for the configuration descriptor source
package ucd_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] STAT_OFF   = 8'h04;
    localparam logic [7:0] CFG0_OFF   = 8'h08;
    localparam logic [7:0] CFG1_OFF   = 8'h0c;
    localparam logic [7:0] CFG2_OFF   = 8'h10;
    localparam logic [7:0] IF0_OFF    = 8'h14;
    localparam logic [7:0] IF1_OFF    = 8'h18;
    localparam logic [7:0] IF2_OFF    = 8'h1c;
    localparam logic [7:0] EPINT_OFF  = 8'h20;
    // Field positions
    localparam int CTRL_LOADED_BIT = 0;
    localparam int STAT_HS_BIT     = 0;
    localparam int STAT_PWR_BIT    = 1;
    localparam int STAT_WAKE_BIT   = 2;
    localparam int STAT_BUSY_BIT   = 3;
    localparam int STAT_STRAP_BIT  = 4;
    // Descriptor codes
    localparam logic [7:0] CFG_LEN    = 8'h09;
    localparam logic [7:0] CFG_TYPE   = 8'h02;
    localparam logic [15:0] TOTAL_LEN = 16'h0027;
    localparam logic [7:0] NUM_IF     = 8'h01;
    localparam logic [7:0] CFG_VALUE  = 8'h01;
    localparam logic [7:0] STR_NONE   = 8'h00;
    localparam logic [7:0] ATTR_DEF   = 8'ha0;
    localparam int ATTR_SELF_BIT      = 6;
    localparam int ATTR_WAKE_BIT      = 5;
    localparam logic [7:0] PWR_SELF   = 8'h01;
    localparam logic [7:0] PWR_BUS    = 8'hfa;
    localparam logic [7:0] IF_LEN     = 8'h09;
    localparam logic [7:0] IF_TYPE    = 8'h04;
    localparam logic [7:0] IF_NUM     = 8'h00;
    localparam logic [7:0] IF_ALT     = 8'h00;
    localparam logic [7:0] IF_NUM_EP  = 8'h03;
    localparam logic [7:0] IF_CLASS   = 8'hff;
    localparam logic [7:0] IF_SUB     = 8'h00;
    localparam logic [7:0] IF_PROTO   = 8'hff;
    localparam logic [7:0] EP_LEN     = 8'h07;
    localparam logic [7:0] EP_TYPE    = 8'h05;
    localparam logic [7:0] EP1_ADDR   = 8'h81;
    localparam logic [7:0] EP2_ADDR   = 8'h02;
    localparam logic [7:0] EP3_ADDR   = 8'h83;
    localparam logic [7:0] EP_BULK    = 8'h02;
    localparam logic [7:0] EP_INTR    = 8'h03;
    localparam logic [7:0] BULK_IVL   = 8'h00;
    localparam logic [15:0] MPS_FS    = 16'd64;
    localparam logic [15:0] MPS_HS    = 16'd512;
    localparam logic [15:0] MPS_INT   = 16'h0010;
    localparam logic [7:0] IVL_HS_DEF = 8'h04;
    localparam logic [7:0] IVL_FS_DEF = 8'h01;
    // Start of each descriptor in the response
    localparam logic [5:0] IF_BASE    = 6'd9;
    localparam logic [5:0] EP1_BASE   = 6'd18;
    localparam logic [5:0] EP2_BASE   = 6'd25;
    localparam logic [5:0] EP3_BASE   = 6'd32;
    // Reset values of stored copies, descriptor byte order
    localparam logic [31:0] CFG0_RST  = 32'h0027_0209;
    localparam logic [31:0] CFG1_RST  = 32'ha000_0101;
    localparam logic [31:0] CFG2_RST  = 32'h0000_00fa;
    localparam logic [31:0] IF0_RST   = 32'h0000_0409;
    localparam logic [31:0] IF1_RST   = 32'hff00_ff03;
    localparam logic [31:0] IF2_RST   = 32'h0000_0000;
    localparam logic [31:0] EPINT_RST = 32'h0000_0401;
    // Strap settle cycles before capture
    localparam logic [1:0] STRAP_WAIT = 2'd3;
    typedef enum logic [0:0] {ST_IDLE, ST_SEND} ucd_state_e;
endpackage

// File: bench/ucd_config_source_properties.sv
// Port checker for the descriptor source, bound to the design
`timescale 1ns/1ps
module ucd_config_source_properties (
    // Clock, reset and APB
    input wire logic        mclk, reset_n, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic        pready, pslverr,
    // Straps, speed, request and stream
    input wire logic        powerSourceStrap, remoteWakeupStrap, highSpeed,
    input wire logic        reqValid, reqReady, txValid, txLast, txReady,
    input wire logic [15:0] reqLength,
    input wire logic [7:0]  txData
);
    localparam logic [7:0] CFG_HDR [6] = '{8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h01};
    localparam logic [7:0] IF_HDR [5] = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h03};
    logic [6:0]  pos;
    logic [6:0]  lastPos;
    logic [15:0] mps;
    assign mps = highSpeed ? 16'd512 : 16'd64;
    // Byte position within the response
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) pos <= 7'd0;
        else if (txValid && txReady) pos <= txLast ? 7'd0 : pos + 7'd1;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) lastPos <= 7'd0;
        else if (reqValid && reqReady)
            lastPos <= (reqLength > 16'd39) ? 7'd38 : reqLength[6:0] - 7'd1;
    end
    function automatic logic [7:0] epByte(logic [7:0] a, logic [7:0] t, logic [6:0] i);
        case (i)
            7'd0: return 8'h07;
            7'd1: return 8'h05;
            7'd2: return a;
            7'd3: return t;
            7'd4: return mps[7:0];
            7'd5: return mps[15:8];
            default: return 8'h00;
        endcase
    endfunction
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_stalled;
        txValid && !txReady;
    endsequence
    sequence s_held;
        txValid && $stable(txData) && $stable(txLast);
    endsequence
    property p_hold; s_stalled |=> s_held; endproperty
    property p_cfgType; txValid && pos == 7'd1 |-> txData == 8'h02; endproperty
    property p_cfgHdr;
        txValid && pos < 7'd6 && pos != 7'd1 |-> txData == CFG_HDR[pos[2:0]];
    endproperty
    property p_ifHdr;
        txValid && pos inside {[9:13]} |-> txData == IF_HDR[pos - 7'd9];
    endproperty
    property p_ep1;
        txValid && pos inside {[18:24]} |-> txData == epByte(8'h81, 8'h02, pos - 7'd18);
    endproperty
    property p_ep2;
        txValid && pos inside {[25:31]} |-> txData == epByte(8'h02, 8'h02, pos - 7'd25);
    endproperty
    property p_ep3;
        txValid && pos inside {[32:35]} |-> txData == epByte(8'h83, 8'h03, pos - 7'd32);
    endproperty
    property p_ep3Mps;
        txValid && pos inside {[36:37]} |-> txData == (pos[0] ? 8'h00 : 8'h10);
    endproperty
    property p_last; txValid |-> txLast == (pos == lastPos); endproperty
    a_hold: assert property (p_hold) else $error("stream changed while stalled");
    a_cfgType: assert property (p_cfgType) else $error("bad config type");
    a_cfgHdr: assert property (p_cfgHdr) else $error("bad config header");
    a_ifHdr: assert property (p_ifHdr) else $error("bad interface header");
    a_ep1: assert property (p_ep1) else $error("bad bulk in endpoint");
    a_ep2: assert property (p_ep2) else $error("bad bulk out endpoint");
    a_ep3: assert property (p_ep3) else $error("bad interrupt endpoint");
    a_ep3Mps: assert property (p_ep3Mps) else $error("bad interrupt size");
    a_last: assert property (p_last) else $error("last flag misplaced");
endmodule

bind ucd_config_source ucd_config_source_properties chk (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerSourceStrap(powerSourceStrap), .remoteWakeupStrap(remoteWakeupStrap),
    .highSpeed(highSpeed), .reqValid(reqValid), .reqReady(reqReady), .txValid(txValid),
    .txLast(txLast), .txReady(txReady), .reqLength(reqLength), .txData(txData)
);

// File: bench/ucd_host_model.sv
// Host side model issuing descriptor requests and taking the bytes
`timescale 1ns/1ps
module ucd_host_model (
    // Clock
    input wire logic        mclk,
    // Request
    output logic            reqValid,
    output logic [15:0]     reqLength,
    input wire logic        reqReady,
    // Byte stream
    input wire logic        txValid,
    input wire logic        txLast,
    input wire logic [7:0]  txData,
    output logic            txReady
);
    logic [7:0]  rxBuf [0:63];
    int          rxCount;
    logic [15:0] stall = 16'hace1;
    initial begin
        reqValid = 1'b0;
        reqLength = 16'h5a5a;
        txReady = 1'b0;
    end
    // One request; slow adds random back-pressure
    task automatic get_desc(input logic [15:0] len, input logic slow);
        int n;
        n = 0;
        rxCount = 0;
        @(posedge mclk);
        reqValid <= 1'b1;
        reqLength <= len;
        do @(posedge mclk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        reqLength <= ~len;
        while (n < 400) begin
            txReady <= slow ? stall[0] : 1'b1;
            stall = {stall[14:0], stall[15] ^ stall[13] ^ stall[12] ^ stall[10]};
            @(posedge mclk);
            n++;
            if (txValid === 1'b1 && txReady === 1'b1) begin
                rxBuf[rxCount[5:0]] = txData;
                rxCount++;
                if (txLast === 1'b1) n = 400;
            end
        end
        txReady <= 1'b0;
    endtask
endmodule

// File: bench/ucd_config_source_tb_top.sv
// Self-checking bench for the descriptor source
`timescale 1ns/1ps
module ucd_config_source_tb_top;
    logic        mclk, reset_n, psel, penable, pwrite, pss, rws, hs;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata, seed;
    logic        pready, pslverr, rerr, reqValid, reqReady, txValid, txLast, txReady;
    logic [15:0] reqLength;
    logic [7:0]  txData;
    // iConfig, attr, power, class, sub, proto, iInterface, interval fs, interval hs
    logic [7:0]  st [0:8];
    int          errors, nChecks;
    localparam logic [31:0] RST_VAL [7] = '{32'h0027_0209, 32'ha000_0101, 32'h0000_00fa,
        32'h0000_0409, 32'hff00_ff03, 32'h0, 32'h0000_0401};
    ucd_config_source uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .powerSourceStrap(pss), .remoteWakeupStrap(rws), .highSpeed(hs),
        .reqValid(reqValid), .reqLength(reqLength), .reqReady(reqReady), .txValid(txValid),
        .txData(txData), .txLast(txLast), .txReady(txReady));
    ucd_host_model host (.mclk(mclk), .reqValid(reqValid), .reqLength(reqLength),
        .reqReady(reqReady), .txValid(txValid), .txLast(txLast), .txData(txData),
        .txReady(txReady));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] expByte(int p);
        logic [7:0]  e [0:38];
        logic [15:0] m;
        m = hs ? 16'd512 : 16'd64;
        e = '{8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h01, st[0], st[1], st[2],
            8'h09, 8'h04, 8'h00, 8'h00, 8'h03, st[3], st[4], st[5], st[6],
            8'h07, 8'h05, 8'h81, 8'h02, m[7:0], m[15:8], 8'h00,
            8'h07, 8'h05, 8'h02, 8'h02, m[7:0], m[15:8], 8'h00,
            8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00, hs ? st[8] : st[7]};
        return e[p];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic p, input logic w);
        reset_n <= 1'b0;
        pss <= p;
        rws <= w;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (8) @(posedge mclk);
        st = '{8'h00, {1'b1, p, w, 5'h00}, p ? 8'h01 : 8'hfa, 8'hff, 8'h00, 8'hff, 8'h00,
            8'h01, 8'h04};
    endtask
    task automatic run(input logic [15:0] len, input logic slow);
        int n;
        n = (len > 16'd39) ? 39 : int'(len);
        host.get_desc(len, slow);
        chk(host.rxCount, n);
        for (int i = 0; i < n; i++) chk(host.rxBuf[i], expByte(i));
    endtask
    task automatic both_speeds(input logic [15:0] len);
        for (int s = 0; s < 2; s++) begin
            hs <= s[0];
            @(posedge mclk);
            run(len, 1'b1);
            run(16'(rnd() % 8'd45) + 16'd1, seed[9]);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (30000) @(posedge mclk);
        errors++;
        test_done();
    end
    initial begin
        {reset_n, psel, penable, pwrite, pss, rws, hs} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        nChecks = 0;
        seed = 32'h7ca1;
        do_reset(1'b0, 1'b1);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'h08 + 8'(4 * i), 32'h0);
            chk(rdata, RST_VAL[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk(rerr, 1'b1);
        run(16'd1, 1'b0);
        run(16'd9, 1'b0);
        run(16'd100, 1'b1);
        both_speeds(16'd39);
        do_reset(1'b1, 1'b0);
        apb(1'b0, ucd_pkg::STAT_OFF, 32'h0);
        chk(rdata, {27'h0, 4'b1001, hs});
        both_speeds(16'd39);
        do_reset(1'b0, 1'b1);
        st = '{rnd(), 8'ha0, 8'hfa, rnd(), rnd(), rnd(), rnd(), rnd() | 8'h01, rnd() | 8'h01};
        apb(1'b1, ucd_pkg::CFG0_OFF, 32'h0027_5509);
        apb(1'b1, ucd_pkg::CFG1_OFF, {8'ha0, st[0], 16'h0101});
        apb(1'b1, ucd_pkg::CFG2_OFF, 32'h0000_00fa);
        apb(1'b1, ucd_pkg::IF1_OFF, {st[5], st[4], st[3], 8'h03});
        apb(1'b1, ucd_pkg::IF2_OFF, {24'h0, st[6]});
        apb(1'b1, ucd_pkg::EPINT_OFF, {16'h0, st[8], st[7]});
        apb(1'b1, ucd_pkg::CTRL_OFF, 32'h1);
        apb(1'b0, ucd_pkg::CTRL_OFF, 32'h0);
        chk(rdata, 32'h1);
        both_speeds(16'd39);
        test_done();
    end
endmodule
